// *** inc/xtrig_pkg.sv ***
package xtrig_pkg;
  localparam int unsigned NUM_CHANNELS = 4;
  localparam int unsigned NUM_INPUTS   = 3;
  localparam logic [7:0] APP_SET_OFS         = 8'h14;
  localparam logic [7:0] APP_TRIGGER_CLEAR   = 8'h18;
  localparam logic [7:0] APP_CHANNEL_PULSE   = 8'h1c;
  localparam logic [7:0] INPUT0_CHANNEL_EN   = 8'h20;
  localparam logic [7:0] INPUT1_CHANNEL_EN   = 8'h24;
  localparam logic [7:0] INPUT2_CHANNEL_EN   = 8'h28;
  localparam logic [7:0] APP_STATE_OFS       = 8'h10;
  localparam int unsigned CHAN_LSB           = 0;
  localparam logic [3:0] APP_STATE_RESET     = 4'h0;
  localparam logic [3:0] ROUTE_RESET         = 4'h0;
  localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;
endpackage

// *** logic/cross_trigger_app_channel_map.sv ***
// Overview of operation
// - Writing one to a clear bit zeroes that trigger state and its event.
// - Zero bits written to clear or pulse registers change nothing.
// - Clear register at 0x018, four disable bits, upper bits read zero.
// - Clear and pulse writes are ignored while the lock flag is set.
// - Pulse bit one emits one event pulse, trigger state untouched.
// - Pulse register has four channel bits; upper bits read zero.
// - Enabled route bit passes an input trigger event to its channel.
// - Disabled route bit blocks that input trigger from that channel.
// - Route enable registers at 0x20, 0x24, 0x28 for inputs 0 to 2.
// - Route enable registers become read-only while locked.
// - Route bits have no guaranteed reset; software must program them.
// - Set register raises the trigger state bit and its channel event.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module cross_trigger_app_channel_map (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        sw_lock_flag_in,
  input  wire logic [2:0]  trig_in,
  output logic      [3:0]  channel_event_out
);
  logic [1:0] lock_sync;
  logic [2:0] trig_sync0;
  logic [2:0] trig_sync1;
  logic       lock_q;
  xtrig_pkg::bus_state_t state;
  xtrig_pkg::bus_state_t next_state;
  logic [3:0]  app_trigger_state;
  logic [3:0]  next_app_trigger_state;
  logic [3:0]  pulse_req;
  logic [3:0]  next_pulse_req;
  logic [3:0]  next_channel_event;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        take;
  logic        wr;
  logic        route_wr;
  logic [1:0]  route_idx;
  logic [3:0]  route_rd;
  logic [11:0] routes;
  logic [3:0]  routed;

  function automatic logic [1:0] route_index(input logic [7:0] adr);
    case (adr)
      xtrig_pkg::INPUT0_CHANNEL_EN: route_index = 2'd0;
      xtrig_pkg::INPUT1_CHANNEL_EN: route_index = 2'd1;
      xtrig_pkg::INPUT2_CHANNEL_EN: route_index = 2'd2;
      default:                      route_index = 2'd3;
    endcase
  endfunction

  // Route nibble of one input; index 3 names no route register
  function automatic logic [3:0] route_of(input logic [11:0] packed_routes,
                                          input logic [1:0]  idx);
    case (idx)
      2'd0:    route_of = packed_routes[3:0];
      2'd1:    route_of = packed_routes[7:4];
      2'd2:    route_of = packed_routes[11:8];
      default: route_of = 4'h0;
    endcase
  endfunction

  // Pins from other domains pass two flops before use
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_sync  <= 2'b00;
      trig_sync0 <= 3'b000;
      trig_sync1 <= 3'b000;
    end else begin
      lock_sync  <= {lock_sync[0], sw_lock_flag_in};
      trig_sync0 <= trig_in;
      trig_sync1 <= trig_sync0;
    end
  end
  assign lock_q = lock_sync[1];

  // One request per ack; ack drops the cycle after it is given
  assign take      = wb_cyc_in && wb_stb_in && state == xtrig_pkg::BUS_IDLE;
  assign wr        = take && wb_we_in && wb_sel_in[0];
  assign route_idx = route_index(wb_adr_in);
  assign route_wr  = wr && !lock_q && route_idx != 2'd3;

  route_store u_routes (
    .ref_clk_in     (ref_clk_in),
    .nrst_in        (nrst_in),
    .wr_en_in       (route_wr),
    .wr_idx_in      (route_idx),
    .wr_data_in     (wb_dat_in[3:0]),
    .rd_idx_in      (route_idx),
    .rd_data_out    (route_rd),
    .all_routes_out (routes)
  );

  always_comb begin
    routed = 4'h0;
    for (int n = 0; n < 3; n++) begin
      if (trig_sync1[n]) begin
        routed = routed | route_of(routes, 2'(n));
      end
    end
  end

  always_comb begin
    next_state             = xtrig_pkg::BUS_IDLE;
    next_ack               = 1'b0;
    next_app_trigger_state = app_trigger_state;
    next_pulse_req         = 4'h0;
    case (state)
      xtrig_pkg::BUS_IDLE: begin
        if (take) begin
          next_state = xtrig_pkg::BUS_ACK;
          next_ack   = 1'b1;
        end
        if (wr && !lock_q) begin
          case (wb_adr_in)
            xtrig_pkg::APP_SET_OFS:
              next_app_trigger_state =
                app_trigger_state | wb_dat_in[3:0];
            xtrig_pkg::APP_TRIGGER_CLEAR:
              next_app_trigger_state =
                app_trigger_state & ~wb_dat_in[3:0];
            xtrig_pkg::APP_CHANNEL_PULSE:
              next_pulse_req = wb_dat_in[3:0];
            default: ;
          endcase
        end
      end
      xtrig_pkg::BUS_ACK: next_state = xtrig_pkg::BUS_IDLE;
      default:            next_state = xtrig_pkg::BUS_IDLE;
    endcase
    next_channel_event = next_app_trigger_state | next_pulse_req | routed;
  end

  // Read data: write-only registers and reserved bits read zero
  always_comb begin
    next_dat = xtrig_pkg::UNMAPPED_READ;
    case (wb_adr_in)
      xtrig_pkg::APP_SET_OFS,
      xtrig_pkg::APP_STATE_OFS: next_dat = {28'h0, app_trigger_state};
      // Read taken straight from the stored routes (all_routes_out); wb_dat_out registers it
      xtrig_pkg::INPUT0_CHANNEL_EN,
      xtrig_pkg::INPUT1_CHANNEL_EN,
      xtrig_pkg::INPUT2_CHANNEL_EN:
        next_dat = {28'h0, route_of(routes, route_idx)};
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state             <= xtrig_pkg::BUS_IDLE;
      wb_ack_out        <= 1'b0;
      wb_dat_out        <= 32'h0;
      app_trigger_state <= xtrig_pkg::APP_STATE_RESET;
      pulse_req         <= 4'h0;
      channel_event_out <= 4'h0;
    end else begin
      state             <= next_state;
      wb_ack_out        <= next_ack;
      wb_dat_out        <= next_dat;
      app_trigger_state <= next_app_trigger_state;
      pulse_req         <= next_pulse_req;
      channel_event_out <= next_channel_event;
    end
  end

  // Store read port runs a cycle behind; kept to cross-check reads
  logic route_rd_pending;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      route_rd_pending <= 1'b0;
    end else begin
      route_rd_pending <= take && route_idx != 2'd3;
    end
  end

  // Checks use the synced copies; raw pins run two cycles ahead
  a_clear_effect : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (wr && !lock_q && wb_adr_in == xtrig_pkg::APP_TRIGGER_CLEAR)
    |=> ((app_trigger_state & $past(wb_dat_in[3:0])) == 4'h0))
    else $error("clear did not zero state");
  a_clear_event : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (wr && !lock_q && wb_adr_in == xtrig_pkg::APP_TRIGGER_CLEAR &&
     trig_sync1 == 3'b000)
    |=> ((channel_event_out & $past(wb_dat_in[3:0])) == 4'h0))
    else $error("clear left channel event");
  a_clear_others : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (wr && !lock_q && wb_adr_in == xtrig_pkg::APP_TRIGGER_CLEAR)
    |=> ((app_trigger_state & ~$past(wb_dat_in[3:0])) ==
         ($past(app_trigger_state) & ~$past(wb_dat_in[3:0]))))
    else $error("clear touched unwritten bits");
  a_wo_read : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (take && !wb_we_in && (wb_adr_in == xtrig_pkg::APP_TRIGGER_CLEAR ||
                           wb_adr_in == xtrig_pkg::APP_CHANNEL_PULSE))
    |=> wb_dat_out == 32'h0)
    else $error("write-only register read nonzero");
  a_locked_hold : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (take && lock_q)
    |=> $stable(app_trigger_state) && pulse_req == 4'h0)
    else $error("locked write changed state");
  a_pulse_once : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (pulse_req != 4'h0)
    |=> pulse_req == 4'h0)
    else $error("pulse longer than one cycle");
  a_pulse_keeps : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (wr && wb_adr_in == xtrig_pkg::APP_CHANNEL_PULSE)
    |=> $stable(app_trigger_state))
    else $error("pulse altered state");
  a_pulse_event : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (wr && !lock_q && wb_adr_in == xtrig_pkg::APP_CHANNEL_PULSE)
    |=> ((channel_event_out & $past(wb_dat_in[3:0])) ==
         $past(wb_dat_in[3:0])))
    else $error("pulse event missing");
  a_pulse_drop : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (wr && !lock_q && wb_adr_in == xtrig_pkg::APP_CHANNEL_PULSE)
    ##1 (trig_sync1 == 3'b000)
    |=> ((channel_event_out & $past(wb_dat_in[3:0], 2) &
          ~app_trigger_state) == 4'h0))
    else $error("pulse event did not end");
  a_pulse_bits : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (wr && !lock_q && wb_adr_in == xtrig_pkg::APP_CHANNEL_PULSE)
    |=> pulse_req == $past(wb_dat_in[3:0]))
    else $error("pulse bits not taken from low nibble");
  a_set_effect : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (wr && !lock_q && wb_adr_in == xtrig_pkg::APP_SET_OFS)
    |=> ##1 ((channel_event_out & $past(wb_dat_in[3:0], 2)) ==
             $past(wb_dat_in[3:0], 2)))
    else $error("set did not raise channel");
  a_set_hold : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (wr && !lock_q && wb_adr_in == xtrig_pkg::APP_SET_OFS)
    |=> ((app_trigger_state & $past(wb_dat_in[3:0])) ==
         $past(wb_dat_in[3:0])))
    else $error("set did not raise state");
  a_route_block : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (app_trigger_state == 4'h0 && trig_sync1 == 3'b000 && !wr)
    |=> channel_event_out == 4'h0)
    else $error("event without cause");
  a_route_exact : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (trig_sync1 == 3'b001 && app_trigger_state == 4'h0 && !wr)
    |=> channel_event_out == $past(routes[3:0]))
    else $error("disabled route raised channel");
  a_route_pass : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (trig_sync1[0])
    |=> ((channel_event_out & $past(routes[3:0])) == $past(routes[3:0])))
    else $error("routed event missing");
  a_route_in2 : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (trig_sync1[2])
    |=> ((channel_event_out & $past(routes[11:8])) == $past(routes[11:8])))
    else $error("input two event missing");
  a_trig_delay : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    trig_sync1 == $past(trig_in, 2))
    else $error("trigger sync depth wrong");
  a_route_upper : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (take && route_idx != 2'd3)
    |=> wb_dat_out[31:4] == 28'h0)
    else $error("route reserved bits nonzero");
  a_route_read : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    route_rd_pending
    |-> wb_dat_out == {28'h0, route_rd})
    else $error("route read data disagree");
  a_route_write : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (wr && !lock_q && route_idx == 2'd1)
    |=> routes[7:4] == $past(wb_dat_in[3:0]))
    else $error("route write not stored");
  a_route_lock : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (take && lock_q)
    |=> $stable(routes))
    else $error("locked route write");
  a_lock_delay : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    lock_q == $past(sw_lock_flag_in, 2))
    else $error("lock sync depth wrong");
  // Single wait state; a master that holds stb past the ack gets a second ack
  a_ack_pulse : assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    take
    |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not single cycle");
  c_clear : cover property (@(posedge ref_clk_in)
    wr && wb_adr_in == xtrig_pkg::APP_TRIGGER_CLEAR);
  c_pulse : cover property (@(posedge ref_clk_in) pulse_req != 4'h0);
  c_locked : cover property (@(posedge ref_clk_in) take && lock_q);
  c_routed : cover property (@(posedge ref_clk_in) routed != 4'h0);
  c_set : cover property (@(posedge ref_clk_in)
    wr && wb_adr_in == xtrig_pkg::APP_SET_OFS);
endmodule
`default_nettype wire

// *** logic/route_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module route_store (
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       wr_en_in,
  input  wire logic [1:0] wr_idx_in,
  input  wire logic [3:0] wr_data_in,
  input  wire logic [1:0] rd_idx_in,
  output logic      [3:0] rd_data_out,
  output logic      [11:0] all_routes_out
);
  logic [3:0] mem [0:2];
  logic [3:0] next_mem [0:2];
  logic [3:0] next_rd_data;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_mem[i] = mem[i];
    end
    if (wr_en_in && wr_idx_in < 2'd3) begin
      next_mem[wr_idx_in] = wr_data_in;
    end
    next_rd_data = (rd_idx_in < 2'd3) ? mem[rd_idx_in] : 4'h0;
  end

  // Reset value is a defined zero; software must still program routes
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 3; i++) begin
        mem[i] <= xtrig_pkg::ROUTE_RESET;
      end
      rd_data_out <= 4'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        mem[i] <= next_mem[i];
      end
      rd_data_out <= next_rd_data;
    end
  end

  assign all_routes_out = {mem[2], mem[1], mem[0]};
endmodule
`default_nettype wire

// *** test/tb_cross_trigger_app_channel_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_cross_trigger_app_channel_map;
  logic        clk;
  logic        nrst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        lock;
  logic [2:0]  want;
  logic [2:0]  trig;
  logic [3:0]  ev;
  logic [31:0] rd;
  int          fail_count;
  int          checks;
  int          cyc_count;
  int          hits;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
  cross_trigger_app_channel_map DUT (
    .ref_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .sw_lock_flag_in(lock),
    .trig_in(trig), .channel_event_out(ev));
  trig_source_model src (
    .ref_clk_in(clk), .nrst_in(nrst), .want_in(want), .trig_out(trig));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Request held until ack is seen on a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wait_ev(input int c, input logic [3:0] e);
    hits = 0;
    repeat (c) begin
      @(posedge clk);
      hits += int'(ev === e);
    end
  endtask
  task automatic t_route;
    wb(1'b1, 8'h20, 32'hffff_fff5);
    wb(1'b1, 8'h24, 32'h0000_0002);
    wb(1'b1, 8'h28, 32'h0000_0008);
    wb(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0000_0005)
    wb(1'b0, 8'h24, 32'h0);
    `CHK(rd, 32'h0000_0002)
    wb(1'b0, 8'h28, 32'h0);
    `CHK(rd, 32'h0000_0008)
    want <= 3'b001;
    wait_ev(5, 4'h5);
    `CHK(ev, 4'h5)
    want <= 3'b110;
    wait_ev(5, 4'ha);
    `CHK(ev, 4'ha)
    want <= 3'b000;
    wait_ev(5, 4'h0);
    $display("route test done");
  endtask
  task automatic t_app;
    wb(1'b1, 8'h14, 32'h0000_000f);
    wait_ev(3, 4'hf);
    `CHK(ev, 4'hf)
    wb(1'b1, 8'h18, 32'hffff_fff3);
    wait_ev(3, 4'hc);
    `CHK(ev, 4'hc)
    wb(1'b1, 8'h18, 32'h0);
    wait_ev(3, 4'hc);
    `CHK(ev, 4'hc)
    // Pulse stands one cycle, so the watcher runs beside the write
    fork
      wb(1'b1, 8'h1c, 32'h0000_0003);
      wait_ev(5, 4'hf);
    join
    `CHK(hits, 1)
    wb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0000_000c)
    wb(1'b0, 8'h18, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, 8'h1c, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b1, 8'h18, 32'h0000_000f);
    fork
      wb(1'b1, 8'h1c, 32'hffff_fff0);
      wait_ev(5, 4'h0);
    join
    `CHK(hits, 5)
    $display("app test done");
  endtask
  task automatic t_lock;
    wb(1'b1, 8'h14, 32'h0000_0001);
    lock <= 1'b1;
    repeat (4) @(posedge clk);
    wb(1'b1, 8'h18, 32'h0000_000f);
    fork
      wb(1'b1, 8'h1c, 32'h0000_0002);
      wait_ev(5, 4'h1);
    join
    `CHK(hits, 5)
    wb(1'b1, 8'h20, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0000_0005)
    wb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    lock <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b1, 8'h18, 32'h0000_0001);
    wait_ev(3, 4'h0);
    `CHK(ev, 4'h0)
    $display("lock test done");
  endtask
  task automatic wrap_up;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Whole run is about 120 cycles; ceiling leaves ample margin
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    {nrst, cyc, stb, we, adr, wdat, lock, want} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_route();
    t_app();
    t_lock();
    wrap_up();
  end
endmodule
`default_nettype wire

// *** test/trig_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module trig_source_model (
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic [2:0] want_in,
  output logic      [2:0] trig_out
);
  // Levels move only on the clock edge, like a clocked trigger source
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trig_out <= 3'h0;
    end else begin
      trig_out <= want_in;
    end
  end
endmodule
`default_nettype wire
